// [hw/message_routing_control.sv]
// Character routing between local sources, line and printer and punch
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "routing_defines.svh"
module message_routing_control
    import routing_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [`ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    output logic [1:0] s_axi_bresp, // Write response
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    input wire logic [`ADDR_W-1:0] s_axi_araddr, // Read address
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    input wire logic kbdValid, // Keyboard character offered
    input wire logic [7:0] kbdData, // Keyboard character
    output logic kbdAck, // Keyboard character taken
    input wire logic tapeValid, // Tape reader character offered
    input wire logic [7:0] tapeData, // Tape reader character
    output logic tapeAck, // Tape reader character taken
    input wire logic rxValid, // Line receiver character offered
    input wire logic [7:0] rxData, // Decoded received character
    output logic rxAck, // Received character taken
    input wire logic rxError, // Receiver error pulse
    output logic txValid, // Character for line transmitter
    output logic [7:0] txData, // Encoded line character
    input wire logic txReady, // Transmitter accepts
    output logic prnValid, // Character for printer
    output logic [7:0] prnData, // Printer character
    input wire logic prnReady, // Printer accepts
    output logic punchValid, // Character for tape punch
    output logic [7:0] punchData, // Punch character
    input wire logic punchReady, // Punch accepts
    input wire logic attachPin, // Tape attachment present
    input wire logic storeFittedPin, // Message store fitted
    input wire logic expandFittedPin, // Memory expansion fitted
    input wire logic [7:0] optSwitch, // Option switches
    output logic shiftLockLamp, // Shift lock lamp
    output logic capsLockLamp, // Caps lock lamp
    output logic lineConnectedIndicator, // On-line lamp
    output logic storedMessageIndicator, // Stored message lamp
    output logic errorLamp, // Error lamp
    output logic [3:0] lineSpeedSel, // Line speed select
    output logic fiveUnitCode, // Five-unit code selected
    output logic doubleSpacing // Printer double line spacing
);
    // Pin synchronisers, first stage read only by second
    logic [10:0] pinMeta_r;
    logic [10:0] pinSync_r;
    logic attach;
    logic storeFitted;
    logic expandFitted;
    logic [7:0] opt;

    always_ff @(posedge core_clk)
    begin
        pinMeta_r <= {expandFittedPin, storeFittedPin, attachPin, optSwitch};
        pinSync_r <= pinMeta_r;
    end

    assign opt = pinSync_r[7:0];
    assign attach = pinSync_r[8];
    assign storeFitted = pinSync_r[9];
    assign expandFitted = pinSync_r[10];

    // Register bus slave
    logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
    logic [`ADDR_W-1:0] awAddr_r, awAddr_nxt;
    logic [31:0] wData_r, wData_nxt;
    logic [3:0] wStrb_r, wStrb_nxt;
    logic bValid_r, bValid_nxt, arReady_r, arReady_nxt;
    logic rValid_r, rValid_nxt;
    logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
    logic [31:0] rData_r, rData_nxt, statWord;
    logic doWr, ctrlWr;
    logic [`CTRL_W-1:0] ctrl_r, ctrl_nxt;

    assign doWr = awHeld_r && wHeld_r && !bValid_r;
    assign ctrlWr = doWr && (awAddr_r == `OFF_CTRL);

    always_comb
    begin
        awHeld_nxt = awHeld_r;
        awAddr_nxt = awAddr_r;
        wHeld_nxt = wHeld_r;
        wData_nxt = wData_r;
        wStrb_nxt = wStrb_r;
        bValid_nxt = bValid_r;
        bResp_nxt = bResp_r;
        arReady_nxt = arReady_r;
        rValid_nxt = rValid_r;
        rData_nxt = rData_r;
        rResp_nxt = rResp_r;
        if (s_axi_awvalid && !awHeld_r)
        begin
            awHeld_nxt = 1'b1;
            awAddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wHeld_r)
        begin
            wHeld_nxt = 1'b1;
            wData_nxt = s_axi_wdata;
            wStrb_nxt = s_axi_wstrb;
        end
        if (doWr)
        begin
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt = (awAddr_r == `OFF_CTRL || awAddr_r == `OFF_STAT) ?
                `RESP_OK : `RESP_SLVERR;
        end
        else if (bValid_r && s_axi_bready)
        begin
            bValid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arReady_r)
        begin
            arReady_nxt = 1'b0;
            rValid_nxt = 1'b1;
            rResp_nxt = `RESP_OK;
            case (s_axi_araddr)
                `OFF_CTRL: rData_nxt = {26'h0, ctrl_r};
                `OFF_STAT: rData_nxt = statWord;
                default:
                begin
                    rData_nxt = 32'h0;
                    rResp_nxt = `RESP_SLVERR;
                end
            endcase
        end
        else if (rValid_r && s_axi_rready)
        begin
            rValid_nxt = 1'b0;
            arReady_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h0;
            wHeld_r <= 1'b0;
            wData_r <= 32'h0;
            wStrb_r <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r <= 2'h0;
            arReady_r <= 1'b1;
            rValid_r <= 1'b0;
            rData_r <= 32'h0;
            rResp_r <= 2'h0;
        end
        else
        begin
            awHeld_r <= awHeld_nxt;
            awAddr_r <= awAddr_nxt;
            wHeld_r <= wHeld_nxt;
            wData_r <= wData_nxt;
            wStrb_r <= wStrb_nxt;
            bValid_r <= bValid_nxt;
            bResp_r <= bResp_nxt;
            arReady_r <= arReady_nxt;
            rValid_r <= rValid_nxt;
            rData_r <= rData_nxt;
            rResp_r <= rResp_nxt;
        end
    end

    assign s_axi_awready = !awHeld_r;
    assign s_axi_wready = !wHeld_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;

    // Control, lamps and options
    logic msgStored_r, msgStored_nxt, err_r, err_nxt;
    logic [9:0] lamps_r, lamps_nxt;
    logic line_connected_indicator, fdx, punchOn, storeCmd, delCmd, errClr;
    logic [`CNT_W-1:0] count_r, count_nxt, cap;

    assign line_connected_indicator = ctrl_r[`CTRL_LINE_CONNECTED_INDICATOR];
    assign fdx = ctrl_r[`CTRL_FDX];
    assign punchOn = ctrl_r[`CTRL_PUNCH];
    assign storeCmd = ctrlWr && wStrb_r[0] && wData_r[`CTRL_STORE];
    assign delCmd = ctrlWr && wStrb_r[0] && wData_r[`CTRL_DELETE];
    assign errClr = ctrlWr && wStrb_r[1] && wData_r[`CTRL_ERRCLR];
    assign statWord = {count_r, opt, 3'h0, msgStored_r, err_r, expandFitted,
        storeFitted, attach};

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (ctrlWr && wStrb_r[0])
        begin
            ctrl_nxt = wData_r[`CTRL_W-1:0];
        end
        msgStored_nxt = storeFitted && (storeCmd || (msgStored_r && !delCmd));
        err_nxt = rxError || (err_r && !errClr);
        lamps_nxt = {opt[`OPT_SPACE], opt[`OPT_CODE], opt[3:0],
            ctrl_r[`CTRL_CAPS], ctrl_r[`CTRL_SHIFT], msgStored_r, line_connected_indicator};
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ctrl_r <= 6'h0;
            err_r <= 1'b0;
            lamps_r <= 10'h0;
            // Battery-held store survives reset
            msgStored_r <= msgStored_r && storeFitted;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            err_r <= err_nxt;
            lamps_r <= lamps_nxt;
            msgStored_r <= msgStored_nxt;
        end
    end

    assign lineConnectedIndicator = lamps_r[0];
    assign storedMessageIndicator = lamps_r[1];
    assign shiftLockLamp = lamps_r[2];
    assign capsLockLamp = lamps_r[3];
    assign lineSpeedSel = lamps_r[7:4];
    assign fiveUnitCode = lamps_r[8];
    assign doubleSpacing = lamps_r[9];
    assign errorLamp = err_r;

    // Routing
    logic [7:0] kbdEnc, tapeEnc;

    code_encoder kbdCoder (.fiveUnit(opt[`OPT_CODE]), .din(kbdData),
        .dout(kbdEnc));
    code_encoder tapeCoder (.fiveUnit(opt[`OPT_CODE]), .din(tapeData),
        .dout(tapeEnc));

    src_t sel;
    logic take, needQ, needT, needP, qFree, txFree, punchFree;
    logic okRx, okTape, okKbd, pushQ, popQ;
    logic [2:0] ack_r, ack_nxt;
    logic txValid_r, txValid_nxt, punchValid_r, punchValid_nxt;
    logic prnValid_r, prnValid_nxt, readPend_r, readPend_nxt;
    logic [7:0] txData_r, txData_nxt, punchData_r, punchData_nxt;
    logic [7:0] prnData_r, prnData_nxt;
    logic [`CNT_W-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;

    mem_port_if memPort ();
    char_store_mem store (.core_clk(core_clk), .port(memPort));

    assign cap = (ctrl_r[`CTRL_EXPAND] && expandFitted) ? `EXP_CAP
        : `BASIC_CAP;
    assign qFree = count_r < cap;
    assign txFree = !txValid_r || txReady;
    assign punchFree = !punchValid_r || punchReady;
    // received characters need printer and maybe punch
    assign okRx = rxValid && !ack_r[0] && line_connected_indicator && qFree
        && (!(attach && punchOn) || punchFree);
    // tape goes to line on-line, printer off-line
    assign okTape = tapeValid && !ack_r[1]
        && (line_connected_indicator ? txFree : qFree);
    assign okKbd = kbdValid && !ack_r[2]
        && (line_connected_indicator ? (txFree && (fdx || qFree)
        && (!(attach && punchOn) || punchFree))
        : (qFree && (!attach || punchFree)));

    always_comb
    begin
        needQ = 1'b0;
        needT = 1'b0;
        needP = 1'b0;
        // one character per cycle, transmit order kept
        if (okRx)
        begin
            sel = SRC_RX;
        end
        else if (okTape)
        begin
            sel = SRC_TAPE;
        end
        else if (okKbd)
        begin
            sel = SRC_KBD;
        end
        else
        begin
            sel = SRC_NONE;
        end
        case (sel)
            SRC_RX:
            begin
                needQ = 1'b1;
                needP = attach && punchOn;
            end
            SRC_TAPE:
            begin
                needT = line_connected_indicator;
                needQ = !line_connected_indicator;
            end
            SRC_KBD:
            begin
                needT = line_connected_indicator;
                needQ = !line_connected_indicator || !fdx;
                needP = attach && (punchOn || !line_connected_indicator);
            end
            default: needQ = 1'b0;
        endcase
    end

    assign take = (sel != SRC_NONE);
    assign pushQ = take && needQ;
    assign popQ = (count_r != 16'h0) && !readPend_r
        && (!prnValid_r || prnReady);

    assign memPort.we = pushQ;
    assign memPort.waddr = wrPtr_r;
    assign memPort.wdata = (sel == SRC_RX) ? rxData
        : ((sel == SRC_TAPE) ? tapeData : kbdData);
    assign memPort.raddr = rdPtr_r;

    always_comb
    begin
        ack_nxt = {sel == SRC_KBD, sel == SRC_TAPE, sel == SRC_RX};
        count_nxt = count_r + {15'h0, pushQ} - {15'h0, popQ};
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        if (pushQ)
        begin
            wrPtr_nxt = (wrPtr_r == `EXP_CAP - 16'h1) ? 16'h0 : wrPtr_r + 16'h1;
        end
        if (popQ)
        begin
            rdPtr_nxt = (rdPtr_r == `EXP_CAP - 16'h1) ? 16'h0 : rdPtr_r + 16'h1;
        end
        readPend_nxt = popQ;
        prnValid_nxt = prnValid_r && !prnReady;
        prnData_nxt = prnData_r;
        if (readPend_r)
        begin
            prnValid_nxt = 1'b1;
            prnData_nxt = memPort.rdata;
        end
        txValid_nxt = txValid_r && !txReady;
        txData_nxt = txData_r;
        if (take && needT)
        begin
            txValid_nxt = 1'b1;
            txData_nxt = (sel == SRC_TAPE) ? tapeEnc : kbdEnc;
        end
        punchValid_nxt = punchValid_r && !punchReady;
        punchData_nxt = punchData_r;
        if (take && needP)
        begin
            punchValid_nxt = 1'b1;
            punchData_nxt = (sel == SRC_RX) ? rxData : kbdEnc;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ack_r <= 3'h0;
            count_r <= 16'h0;
            wrPtr_r <= 16'h0;
            rdPtr_r <= 16'h0;
            readPend_r <= 1'b0;
            prnValid_r <= 1'b0;
            prnData_r <= 8'h0;
            txValid_r <= 1'b0;
            txData_r <= 8'h0;
            punchValid_r <= 1'b0;
            punchData_r <= 8'h0;
        end
        else
        begin
            ack_r <= ack_nxt;
            count_r <= count_nxt;
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            readPend_r <= readPend_nxt;
            prnValid_r <= prnValid_nxt;
            prnData_r <= prnData_nxt;
            txValid_r <= txValid_nxt;
            txData_r <= txData_nxt;
            punchValid_r <= punchValid_nxt;
            punchData_r <= punchData_nxt;
        end
    end

    assign rxAck = ack_r[0];
    assign tapeAck = ack_r[1];
    assign kbdAck = ack_r[2];
    assign txValid = txValid_r;
    assign txData = txData_r;
    assign prnValid = prnValid_r;
    assign prnData = prnData_r;
    assign punchValid = punchValid_r;
    assign punchData = punchData_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_tx_line_connected_indicator: assert property ($rose(txValid_r) |-> $past(line_connected_indicator))
        else $error("line character sent off-line");
    a_tape_to_line: assert property (take && sel == SRC_TAPE && line_connected_indicator
        |-> !pushQ ##1 txValid_r && txData_r == $past(tapeEnc))
        else $error("tape character misrouted on-line");
    a_kbd_punch: assert property (take && sel == SRC_KBD && line_connected_indicator
        && punchOn && attach |=> punchValid_r
        && punchData_r == $past(kbdEnc))
        else $error("keyboard character not punched");
    a_rx_print: assert property (take && sel == SRC_RX |=> count_r ==
        $past(count_r) + 16'h1 - {15'h0, $past(popQ)})
        else $error("received character not queued");
    a_half_print: assert property (take && sel == SRC_KBD && line_connected_indicator
        |-> pushQ == !fdx)
        else $error("duplex print routing wrong");
    a_tx_hold: assert property (txValid_r && !txReady
        |=> txValid_r && $stable(txData_r))
        else $error("transmit character lost");
    a_offline_kbd: assert property (take && sel == SRC_KBD && !line_connected_indicator
        |-> pushQ && needP == attach && !needT)
        else $error("off-line keyboard routing wrong");
    a_offline_tape: assert property (take && sel == SRC_TAPE && !line_connected_indicator
        |-> pushQ && !needT)
        else $error("off-line tape routing wrong");
    a_line_connected_indicator_lamp: assert property (##1 lineConnectedIndicator
        == $past(line_connected_indicator))
        else $error("on-line lamp wrong");
    a_queue_cap: assert property (pushQ |-> count_r < cap)
        else $error("queue over capacity");
    a_error_lamp: assert property (rxError |=> errorLamp)
        else $error("error not flagged");
    a_store_keep: assert property (msgStored_r && !delCmd && storeFitted
        |=> msgStored_r)
        else $error("stored message lost");
    a_prn_order: assert property (readPend_r
        |=> prnValid_r && prnData_r == $past(memPort.rdata))
        else $error("printer load wrong");

    c_rx_take: cover property (take && sel == SRC_RX);
    c_kbd_line_connected_indicator: cover property (take && sel == SRC_KBD && line_connected_indicator);
    c_tape_offline: cover property (take && sel == SRC_TAPE && !line_connected_indicator);
    c_queue_full: cover property (!qFree && rxValid);
endmodule // message_routing_control

// [hw/routing_defines.svh]
// Constants for the character routing block
`ifndef ROUTING_DEFINES_SVH
`define ROUTING_DEFINES_SVH
`define ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define CTRL_LINE_CONNECTED_INDICATOR 0
`define CTRL_FDX 1
`define CTRL_PUNCH 2
`define CTRL_EXPAND 3
`define CTRL_SHIFT 4
`define CTRL_CAPS 5
`define CTRL_STORE 6
`define CTRL_DELETE 7
`define CTRL_ERRCLR 8
`define CTRL_W 6
`define OPT_CODE 4
`define OPT_SPACE 5
`define CNT_W 16
`define BASIC_CAP 16'h0070
`define EXP_CAP 16'hdc00
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`define FIVE_MASK 8'h1f
`define SEVEN_MASK 8'h7f
`endif

// [hw/routing_pkg.sv]
// Types shared by the character routing block
package routing_pkg;
    typedef enum logic [1:0] {SRC_NONE, SRC_RX, SRC_TAPE, SRC_KBD} src_t;
endpackage

// [hw/mem_port_if.sv]
// Port between queue control and character memory
`timescale 1ns/10ps
`include "routing_defines.svh"
interface mem_port_if;
    logic we;
    logic [`CNT_W-1:0] waddr;
    logic [7:0] wdata;
    logic [`CNT_W-1:0] raddr;
    logic [7:0] rdata;
    modport ctl (output we, waddr, wdata, raddr, input rdata);
    modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// [hw/char_store_mem.sv]
// Character memory of the printer queue
`timescale 1ns/10ps
`include "routing_defines.svh"
module char_store_mem (
    input wire logic core_clk, // System clock
    mem_port_if.mem port // Write and read port
);
    logic [7:0] mem [0:`EXP_CAP-1];
    logic [7:0] rdata_r;

    always_ff @(posedge core_clk)
    begin
        if (port.we)
        begin
            mem[port.waddr] <= port.wdata;
        end
        rdata_r <= mem[port.raddr];
    end

    assign port.rdata = rdata_r;
endmodule // char_store_mem

// [hw/code_encoder.sv]
// Maps a local character into five-unit or seven-bit code
`timescale 1ns/10ps
`include "routing_defines.svh"
module code_encoder (
    input wire logic fiveUnit, // High selects five-unit code
    input wire logic [7:0] din, // Character from a local source
    output logic [7:0] dout // Encoded character
);
    // Five-unit code keeps the low five bits
    always_comb
    begin
        dout = fiveUnit ? (din & `FIVE_MASK) : (din & `SEVEN_MASK);
    end
endmodule // code_encoder

// [dv/line_partner.sv]
// Remote line equipment: takes transmitted characters, sends received ones
`timescale 1ns/10ps
module line_partner (
    input wire logic core_clk, // System clock
    input wire logic txValid, // Line character offered
    input wire logic [7:0] txData, // Line character
    output logic txReady, // Line takes character
    output logic rxValid, // Received character offered
    output logic [7:0] rxData, // Received character
    input wire logic rxAck, // Received character taken
    input wire logic slow // Accept only every other cycle
);
    int txN = 0;
    logic [7:0] txD = 8'h00;
    logic ackT = 1'h0;
    logic ph = 1'h0;
    initial
    begin
        txReady = 1'h1;
        rxValid = 1'h0;
        rxData = 8'h00;
    end
    always @(posedge core_clk)
    begin
        ackT <= rxAck;
        ph <= ~ph;
        txReady <= slow ? ph : 1'h1;
        if (txValid && txReady)
        begin
            txN <= txN + 1;
            txD <= txData;
        end
    end
    task automatic sendRx(input logic [7:0] c, output logic ok);
        int n = 0;
        rxData <= c;
        rxValid <= 1'h1;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end while (n < 40 && !ackT);
        ok = ackT;
        rxValid <= 1'h0;
        // Released data shows no stale character
        rxData <= ~c;
    endtask
endmodule // line_partner

// [dv/message_routing_control_bench.sv]
// Self-checking bench for the character routing block
`timescale 1ns/10ps
`include "routing_defines.svh"
module message_routing_control_bench;
    logic core_clk = 1'h0, srst = 1'h1, slow = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = 4'hf, lineSpeedSel;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, kbdAck, tapeAck, rxValid, rxAck, txValid, txReady;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic kbdValid = 1'h0, tapeValid = 1'h0, rxError = 1'h0;
    logic [7:0] kbdData = 8'h00, tapeData = 8'h00, prnD = 8'h00;
    logic [7:0] punD = 8'h00;
    logic [7:0] rxData, txData, prnData, punchData;
    logic prnValid, punchValid, prnReady = 1'h1, punchReady = 1'h1;
    logic attachPin = 1'h1, storeFittedPin = 1'h0, expandFittedPin = 1'h0;
    logic [7:0] optSwitch = 8'h03;
    logic shiftLockLamp, capsLockLamp, lineConnectedIndicator;
    logic storedMessageIndicator, errorLamp, fiveUnitCode, doubleSpacing;
    logic awT = 1'h0, wT = 1'h0, bT = 1'h0, arT = 1'h0, rT = 1'h0;
    logic kT = 1'h0, tT = 1'h0;
    int prnN = 0, punN = 0, err_count = 0, num_checks = 0;
    message_routing_control uut (.*);
    line_partner lp (.*);
    initial
        forever #2.5 core_clk = ~core_clk;
    // Captures handshakes and sink traffic as seen at each edge
    always @(posedge core_clk)
    begin
        awT <= s_axi_awvalid && s_axi_awready;
        wT <= s_axi_wvalid && s_axi_wready;
        bT <= s_axi_bvalid && s_axi_bready;
        arT <= s_axi_arvalid && s_axi_arready;
        rT <= s_axi_rvalid && s_axi_rready;
        resp <= s_axi_bvalid ? s_axi_bresp : s_axi_rresp;
        rdv <= s_axi_rdata;
        kT <= kbdAck;
        tT <= tapeAck;
        if (prnValid && prnReady)
        begin
            prnN <= prnN + 1;
            prnD <= prnData;
        end
        if (punchValid && punchReady)
        begin
            punN <= punN + 1;
            punD <= punchData;
        end
    end
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang(input logic ok);
        if (!ok)
        begin
            err_count++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            tick();
            n++;
            if (awT)
                s_axi_awvalid <= 1'h0;
            if (wT)
                s_axi_wvalid <= 1'h0;
        end while (n < 40 && !bT);
        s_axi_bready <= 1'h0;
        hang(bT);
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            tick();
            n++;
            if (arT)
                s_axi_arvalid <= 1'h0;
        end while (n < 40 && !rT);
        s_axi_rready <= 1'h0;
        hang(rT);
    endtask
    task automatic offer(input int s, input logic [7:0] c);
        int n = 0;
        kbdValid <= (s == 0);
        tapeValid <= (s == 1);
        kbdData <= c;
        tapeData <= c;
        do
        begin
            tick();
            n++;
        end while (n < 40 && !(kT || tT));
        hang(kT || tT);
        kbdValid <= 1'h0;
        tapeValid <= 1'h0;
        kbdData <= ~c;
        tapeData <= ~c;
    endtask
    // Source 0 keyboard, 1 tape, 2 line; expected punch -1 is not judged
    task automatic route(input int s, input logic [7:0] c,
        input int eT, eP, eU, input logic [7:0] eD);
        int t0 = lp.txN, p0 = prnN, u0 = punN;
        logic ok = 1'h1;
        if (s == 2)
            lp.sendRx(c, ok);
        else
            offer(s, c);
        hang(ok);
        repeat (24) tick();
        chk("tx count", eT, lp.txN - t0);
        chk("print count", eP, prnN - p0);
        if (eU >= 0)
            chk("punch count", eU, punN - u0);
        if (eU > 0)
            chk("punch data", c, punD);
        if (eT > 0)
            chk("tx data", eD, lp.txD);
        if (eP > 0)
            chk("print data", c, prnD);
    endtask
    task automatic t_regs();
        rd(`OFF_CTRL);
        chk("ctrl reset", 32'h0, rdv);
        wr(`OFF_CTRL, 32'h1);
        rd(`OFF_CTRL);
        chk("ctrl", 32'h1, rdv);
        chk("lamp on", 32'h1, lineConnectedIndicator);
        rd(`OFF_STAT);
        chk("switches", 32'h03, (rdv >> 8) & 32'hff);
        rd(8'h08);
        chk("unmapped resp", 32'h2, resp);
        $display("test regs done");
    endtask
    task automatic t_offline();
        wr(`OFF_CTRL, 32'h2);
        repeat (2) tick();
        chk("lamp off", 32'h0, lineConnectedIndicator);
        route(0, 8'h41, 0, 1, 1, 8'h00);
        route(1, 8'h42, 0, 1, -1, 8'h00);
        $display("test offline done");
    endtask
    task automatic t_half();
        wr(`OFF_CTRL, 32'h5);
        route(0, 8'h43, 1, 1, 1, 8'h43);
        route(1, 8'h44, 1, 0, -1, 8'h44);
        route(2, 8'h45, 0, 1, 1, 8'h00);
        $display("test half duplex done");
    endtask
    task automatic t_full();
        int t0, p0;
        logic ok;
        wr(`OFF_CTRL, 32'h7);
        slow <= 1'h1;
        route(0, 8'h46, 1, 0, 1, 8'h46);
        t0 = lp.txN;
        p0 = prnN;
        fork
            offer(0, 8'h47);
            lp.sendRx(8'h48, ok);
        join
        hang(ok);
        repeat (24) tick();
        chk("tx count", 32'h1, lp.txN - t0);
        chk("tx data", 32'h47, lp.txD);
        chk("print data", 32'h48, prnD);
        optSwitch <= 8'h33;
        repeat (4) tick();
        chk("five unit", 32'h1, fiveUnitCode);
        chk("double space", 32'h1, doubleSpacing);
        chk("line speed", 32'h3, lineSpeedSel);
        route(0, 8'h5a, 1, 0, -1, 8'h1a);
        $display("test full duplex done");
    endtask
    task automatic t_lamps();
        storeFittedPin <= 1'h1;
        rxError <= 1'h1;
        tick();
        rxError <= 1'h0;
        tick();
        chk("error lamp", 32'h1, errorLamp);
        wr(`OFF_CTRL, 32'h70);
        tick();
        chk("shift lamp", 32'h1, shiftLockLamp);
        chk("caps lamp", 32'h1, capsLockLamp);
        chk("msg lamp", 32'h1, storedMessageIndicator);
        wr(`OFF_CTRL, 32'h130);
        chk("error clear", 32'h0, errorLamp);
        srst <= 1'h1;
        repeat (4) tick();
        srst <= 1'h0;
        repeat (2) tick();
        chk("msg kept", 32'h1, storedMessageIndicator);
        chk("shift reset", 32'h0, shiftLockLamp);
        wr(`OFF_CTRL, 32'h80);
        tick();
        chk("msg deleted", 32'h0, storedMessageIndicator);
        $display("test lamps done");
    endtask
    task automatic t_cap();
        int p0 = prnN;
        prnReady <= 1'h0;
        kbdValid <= 1'h1;
        repeat (260) tick();
        rd(`OFF_STAT);
        chk("queue cap", `BASIC_CAP, rdv >> 16);
        kbdValid <= 1'h0;
        prnReady <= 1'h1;
        repeat (260) tick();
        chk("print all", `BASIC_CAP + 16'h1, prnN - p0);
        $display("test capacity done");
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        srst <= 1'h0;
        tick();
        t_regs();
        t_offline();
        t_half();
        t_full();
        t_lamps();
        t_cap();
        end_sim();
    end
endmodule // message_routing_control_bench
